//--- core/bldc_pkg.sv
// shared constants, register map and carrier types of the commutation core
package bldc_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_PERIOD_NS = 10000;
  localparam int unsigned OSC_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LATCH_DELAY_NS = 10000000;
  localparam int unsigned LATCH_DELAY_CYCLES = LATCH_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned OSC_W = 10;
  localparam int unsigned DLY_W = 24;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DUTY_OFS = 8'h04;
  localparam logic [7:0] STATE_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_LATCH_MODE_BIT = 1;
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FAULT_BIT = 0;
  localparam int unsigned IRQ_CURLIM_BIT = 1;
  localparam int unsigned IRQ_LATCH_BIT = 2;
  localparam int unsigned IRQ_INVALID_BIT = 3;

  // ==========================================================
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;
  localparam logic [OSC_W-1:0] DUTY_RST = 10'h000;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic [2:0] top;
    logic [2:0] bot;
  } drive_t;

  typedef struct packed {
    logic [2:0] hall;
    logic enable;
    logic brake;
    logic fwd;
    logic phase60;
    logic over_current;
    logic [2:0] under_volt;
    logic thermal;
    logic discharge;
  } pins_t;

  localparam int unsigned PINS_W = $bits(pins_t);

endpackage

//--- core/pin_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

//--- core/bldc_core.sv
// six-step commutation, fault logic, pwm latches and axi4-lite register slave
`timescale 1ns/1ps
module bldc_core #(
  parameter int unsigned LATCH_DELAY = bldc_pkg::LATCH_DELAY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hall_input_a,
  input wire logic hall_input_b,
  input wire logic hall_input_c,
  input wire logic out_enable,
  input wire logic brake,
  input wire logic fwd_rev,
  input wire logic phase_sel_60,
  input wire logic over_current,
  input wire logic uv_supply,
  input wire logic uv_drive_supply,
  input wire logic uv_reference,
  input wire logic thermal_shutdown,
  input wire logic shutdown_delay_cap,
  output logic upper_drive_a,
  output logic upper_drive_b,
  output logic upper_drive_c,
  output logic lower_drive_a,
  output logic lower_drive_b,
  output logic lower_drive_c,
  output logic fault_n,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // functions
  // returns {valid, step[2:0]}
  function automatic logic [3:0] decode_code(input logic [2:0] code, input logic p60);
    logic [3:0] r;
    r = 4'h0;
    if (p60) begin
      unique case (code)
        3'b100: r = 4'h8;
        3'b110: r = 4'h9;
        3'b111: r = 4'ha;
        3'b011: r = 4'hb;
        3'b001: r = 4'hc;
        3'b000: r = 4'hd;
        default: r = 4'h0;
      endcase
    end else begin
      unique case (code)
        3'b100: r = 4'h8;
        3'b110: r = 4'h9;
        3'b010: r = 4'ha;
        3'b011: r = 4'hb;
        3'b001: r = 4'hc;
        3'b101: r = 4'hd;
        default: r = 4'h0;
      endcase
    end
    return r;
  endfunction

  // reverse swaps top and bottom so phases stay distinct
  function automatic bldc_pkg::drive_t step_drive(input logic [2:0] step, input logic fwd);
    bldc_pkg::drive_t d;
    d = '0;
    unique case (step)
      3'd0: d = '{top: 3'b100, bot: 3'b001};
      3'd1: d = '{top: 3'b010, bot: 3'b001};
      3'd2: d = '{top: 3'b010, bot: 3'b100};
      3'd3: d = '{top: 3'b001, bot: 3'b100};
      3'd4: d = '{top: 3'b001, bot: 3'b010};
      3'd5: d = '{top: 3'b100, bot: 3'b010};
      default: d = '0;
    endcase
    if (!fwd) begin
      d = '{top: d.bot, bot: d.top};
    end
    return d;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // ==========================================================
  // input synchronisation
  bldc_pkg::pins_t pins_raw;
  bldc_pkg::pins_t pins;

  assign pins_raw = '{hall: {hall_input_a, hall_input_b, hall_input_c},
                      enable: out_enable, brake: brake, fwd: fwd_rev,
                      phase60: phase_sel_60, over_current: over_current,
                      under_volt: {uv_supply, uv_drive_supply, uv_reference},
                      thermal: thermal_shutdown, discharge: shutdown_delay_cap};

  pin_sync #(
    .W(bldc_pkg::PINS_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // ==========================================================
  // register state
  logic [bldc_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [bldc_pkg::OSC_W-1:0] duty_ff, nxt_duty;
  logic [bldc_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [bldc_pkg::IRQ_W-1:0] irq_en_ff, nxt_irq_en;
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // ==========================================================
  // motor state
  logic [bldc_pkg::OSC_W-1:0] osc_ff, nxt_osc;
  logic pwm_on_ff, nxt_pwm_on;
  logic cur_on_ff, nxt_cur_on;
  logic [bldc_pkg::DLY_W-1:0] dly_ff, nxt_dly;
  logic latched_ff, nxt_latched;
  bldc_pkg::drive_t drive_ff, nxt_drive;
  logic fault_ff, nxt_fault;
  logic invalid_ff, nxt_invalid;

  logic [3:0] dec;
  logic code_ok;
  logic uv_any;
  logic enable_eff;
  logic [bldc_pkg::IRQ_W-1:0] events;
  logic wr_fire;
  logic [31:0] wmask;
  logic [bldc_pkg::IRQ_W-1:0] irq_clr;

  assign dec = decode_code(pins.hall, pins.phase60);
  assign code_ok = dec[3];
  assign uv_any = |pins.under_volt;
  // thermal and the latch both act as enable low
  assign enable_eff = pins.enable & ~pins.thermal & ~latched_ff & ctrl_ff[bldc_pkg::CTRL_RUN_BIT];

  // ==========================================================
  // motor next state
  always_comb begin
    nxt_osc = (osc_ff == bldc_pkg::OSC_W'(bldc_pkg::OSC_CYCLES - 1)) ? '0 : osc_ff + 1'b1;
    // latches set once per ramp, reset holds to the next ramp
    if (osc_ff == '0) begin
      nxt_pwm_on = (duty_ff != '0);
      nxt_cur_on = ~pins.over_current;
    end else begin
      nxt_pwm_on = pwm_on_ff & (osc_ff < duty_ff);
      nxt_cur_on = cur_on_ff & ~pins.over_current;
    end
    // delayed latch, cleared only by discharge or reset
    nxt_dly = '0;
    nxt_latched = latched_ff;
    if (pins.discharge) begin
      nxt_latched = 1'b0;
    end else if (ctrl_ff[bldc_pkg::CTRL_LATCH_MODE_BIT] & pins.over_current & ~latched_ff) begin
      nxt_dly = dly_ff + 1'b1;
      if (dly_ff >= bldc_pkg::DLY_W'(LATCH_DELAY - 1)) begin
        nxt_latched = 1'b1;
      end
    end
    nxt_drive = '0;
    if (uv_any) begin
      nxt_drive = '0;
    end else if (pins.brake) begin
      nxt_drive = '{top: 3'b000, bot: 3'b111};
    end else if (code_ok & enable_eff) begin
      // one top and one bottom of different phases
      nxt_drive = step_drive(dec[2:0], pins.fwd);
      // pwm only chops the bottoms
      nxt_drive.bot = nxt_drive.bot & {3{pwm_on_ff & cur_on_ff}};
    end
    // any fault condition pulls the output low
    nxt_fault = ~code_ok | ~enable_eff | pins.over_current | uv_any;
    nxt_invalid = ~code_ok;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      osc_ff <= '0;
      pwm_on_ff <= 1'b0;
      cur_on_ff <= 1'b0;
      dly_ff <= '0;
      latched_ff <= 1'b0;
      drive_ff <= '0;
      fault_ff <= 1'b1;
      // zeros in the sync flops read as invalid, so no false event after reset
      invalid_ff <= 1'b1;
    end else begin
      osc_ff <= nxt_osc;
      pwm_on_ff <= nxt_pwm_on;
      cur_on_ff <= nxt_cur_on;
      dly_ff <= nxt_dly;
      latched_ff <= nxt_latched;
      drive_ff <= nxt_drive;
      fault_ff <= nxt_fault;
      invalid_ff <= nxt_invalid;
    end
  end

  assign {upper_drive_a, upper_drive_b, upper_drive_c} = drive_ff.top;
  assign {lower_drive_a, lower_drive_b, lower_drive_c} = drive_ff.bot;
  assign fault_n = ~fault_ff;

  // ==========================================================
  // interrupt events
  assign events[bldc_pkg::IRQ_FAULT_BIT] = nxt_fault & ~fault_ff;
  assign events[bldc_pkg::IRQ_CURLIM_BIT] = cur_on_ff & ~nxt_cur_on;
  assign events[bldc_pkg::IRQ_LATCH_BIT] = nxt_latched & ~latched_ff;
  assign events[bldc_pkg::IRQ_INVALID_BIT] = nxt_invalid & ~invalid_ff;
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ==========================================================
  // axi4-lite slave next state
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wmask = strb_mask(wstrb_ff);
  assign irq_clr = (wr_fire && awaddr_ff == bldc_pkg::IRQ_CLR_OFS) ?
                   (wdata_ff[bldc_pkg::IRQ_W-1:0] & wmask[bldc_pkg::IRQ_W-1:0]) : '0;
  assign s_axi_awready = ~aw_held_ff;
  assign s_axi_wready = ~w_held_ff;
  assign s_axi_arready = ~rvalid_ff;

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    nxt_duty = duty_ff;
    nxt_irq_en = irq_en_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid & ~aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid & ~w_held_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = bldc_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        bldc_pkg::CTRL_OFS: begin
          nxt_ctrl = (ctrl_ff & ~wmask[bldc_pkg::CTRL_W-1:0]) |
                     (wdata_ff[bldc_pkg::CTRL_W-1:0] & wmask[bldc_pkg::CTRL_W-1:0]);
        end
        bldc_pkg::DUTY_OFS: begin
          nxt_duty = (duty_ff & ~wmask[bldc_pkg::OSC_W-1:0]) |
                     (wdata_ff[bldc_pkg::OSC_W-1:0] & wmask[bldc_pkg::OSC_W-1:0]);
        end
        bldc_pkg::IRQ_EN_OFS: begin
          nxt_irq_en = (irq_en_ff & ~wmask[bldc_pkg::IRQ_W-1:0]) |
                       (wdata_ff[bldc_pkg::IRQ_W-1:0] & wmask[bldc_pkg::IRQ_W-1:0]);
        end
        bldc_pkg::IRQ_CLR_OFS: nxt_bresp = bldc_pkg::RESP_OKAY;
        bldc_pkg::STATE_OFS, bldc_pkg::IRQ_STAT_OFS: nxt_bresp = bldc_pkg::RESP_OKAY;
        default: nxt_bresp = bldc_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_ff & s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid & ~rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = bldc_pkg::RESP_OKAY;
      nxt_rdata = '0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        bldc_pkg::CTRL_OFS: nxt_rdata[bldc_pkg::CTRL_W-1:0] = ctrl_ff;
        bldc_pkg::DUTY_OFS: nxt_rdata[bldc_pkg::OSC_W-1:0] = duty_ff;
        bldc_pkg::STATE_OFS: begin
          nxt_rdata[15:0] = {latched_ff, fault_ff, pwm_on_ff, cur_on_ff,
                             code_ok, dec[2:0], drive_ff, pins.hall[1:0]};
          nxt_rdata[16] = pins.hall[2];
        end
        bldc_pkg::IRQ_STAT_OFS: nxt_rdata[bldc_pkg::IRQ_W-1:0] = irq_stat_ff;
        bldc_pkg::IRQ_EN_OFS: nxt_rdata[bldc_pkg::IRQ_W-1:0] = irq_en_ff;
        bldc_pkg::IRQ_CLR_OFS: nxt_rdata = '0;
        default: nxt_rresp = bldc_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_ff & s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    // set wins over a clear in the same cycle
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | events;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= bldc_pkg::RESP_OKAY;
      ctrl_ff <= bldc_pkg::CTRL_RST;
      duty_ff <= bldc_pkg::DUTY_RST;
      irq_en_ff <= bldc_pkg::IRQ_EN_RST;
      irq_stat_ff <= '0;
      rvalid_ff <= 1'b0;
      rresp_ff <= bldc_pkg::RESP_OKAY;
      rdata_ff <= '0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      ctrl_ff <= nxt_ctrl;
      duty_ff <= nxt_duty;
      irq_en_ff <= nxt_irq_en;
      irq_stat_ff <= nxt_irq_stat;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

endmodule

//--- verification/bldc_core_monitor.sv
// port-level checker of drive and fault behaviour of the commutation core
`timescale 1ns/1ps
module bldc_core_monitor (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hall_input_a,
  input wire logic hall_input_b,
  input wire logic hall_input_c,
  input wire logic out_enable,
  input wire logic brake,
  input wire logic fwd_rev,
  input wire logic phase_sel_60,
  input wire logic over_current,
  input wire logic uv_supply,
  input wire logic uv_drive_supply,
  input wire logic uv_reference,
  input wire logic thermal_shutdown,
  input wire logic upper_drive_a,
  input wire logic upper_drive_b,
  input wire logic upper_drive_c,
  input wire logic lower_drive_a,
  input wire logic lower_drive_b,
  input wire logic lower_drive_c,
  input wire logic fault_n
);
  // ==========================================================
  // helpers
  logic [2:0] up;
  logic [2:0] lo;
  logic [2:0] hall;
  logic uv;
  assign up = {upper_drive_a, upper_drive_b, upper_drive_c};
  assign lo = {lower_drive_a, lower_drive_b, lower_drive_c};
  assign hall = {hall_input_a, hall_input_b, hall_input_c};
  assign uv = uv_supply | uv_drive_supply | uv_reference;
  // three raw samples fill both sync flops and the decode flop
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // properties
  shoot_thru_a: assert property ((up & lo) == 3'h0)
    else $error("top and bottom of one phase on together");
  one_top_a: assert property ($onehot0(up))
    else $error("more than one top drive on");
  uv_off_a: assert property (uv [*3] |=> !fault_n && up == 3'h0 && lo == 3'h0)
    else $error("undervoltage left a drive on");
  thermal_off_a: assert property ((thermal_shutdown && !brake) [*3]
    |=> !fault_n && up == 3'h0 && lo == 3'h0)
    else $error("overtemperature left a drive on");
  disable_off_a: assert property ((!out_enable && !brake) [*3]
    |=> !fault_n && up == 3'h0 && lo == 3'h0)
    else $error("disable left a drive on");
  overcur_fault_a: assert property (over_current [*3] |=> !fault_n)
    else $error("overcurrent without fault");
  invalid_fault_a: assert property ((hall == (phase_sel_60 ? 3'h2 : 3'h7)) [*3]
    |=> !fault_n)
    else $error("invalid code without fault");
  brake_drive_a: assert property ((brake && !uv) [*3] |=> up == 3'h0 && lo == 3'h7)
    else $error("brake drive pattern wrong");
  step_zero_a: assert property ((hall == 3'h4 && fwd_rev && out_enable && !brake
    && !thermal_shutdown && !over_current && !uv) [*3] |=> up == (fault_n ? 3'h4 : 3'h0))
    else $error("code 100 top drive wrong");
endmodule

bind bldc_core bldc_core_monitor i_bldc_core_monitor (
  .clk_sys, .arst_n, .hall_input_a, .hall_input_b, .hall_input_c, .out_enable, .brake,
  .fwd_rev, .phase_sel_60, .over_current, .uv_supply, .uv_drive_supply, .uv_reference,
  .thermal_shutdown, .upper_drive_a, .upper_drive_b, .upper_drive_c, .lower_drive_a,
  .lower_drive_b, .lower_drive_c, .fault_n
);

//--- verification/bldc_motor_model.sv
// rotor and bridge model: hall pattern, current sense and brake switch
`timescale 1ns/1ps
module bldc_motor_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic step,
  input wire logic sel60,
  input wire logic bad,
  input wire logic oc_cmd,
  input wire logic brake_sw,
  output logic hall_input_a,
  output logic hall_input_b,
  output logic hall_input_c,
  output logic over_current,
  output logic brake,
  output logic shutdown_delay_cap
);
  // ==========================================================
  // rotor sector, one 60 degree step per command
  logic [2:0] pos_ff;
  logic [2:0] code;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pos_ff <= 3'h0;
    end else if (step) begin
      pos_ff <= (pos_ff == 3'h5) ? 3'h0 : pos_ff + 3'h1;
    end
  end
  // bad only on command, a broken sensor
  always_comb begin
    case (pos_ff)
      3'h0: code = 3'h4;
      3'h1: code = 3'h6;
      3'h2: code = sel60 ? 3'h7 : 3'h2;
      3'h3: code = 3'h3;
      3'h4: code = 3'h1;
      default: code = sel60 ? 3'h0 : 3'h5;
    endcase
    if (bad) begin
      code = sel60 ? 3'h2 : 3'h7;
    end
  end
  assign {hall_input_a, hall_input_b, hall_input_c} = code;
  assign over_current = oc_cmd;
  // closing the brake switch also discharges the delay
  assign brake = brake_sw;
  assign shutdown_delay_cap = brake_sw;
endmodule

//--- verification/tb_bldc_core.sv
// self-checking bench for the commutation core with a rotor and bridge model
`timescale 1ns/1ps
module tb_bldc_core;
  logic clk_sys, arst_n, out_enable, fwd_rev, phase_sel_60, thermal_shutdown;
  logic step, bad, oc_cmd, brake_sw, hall_input_a, hall_input_b, hall_input_c;
  logic over_current, brake, shutdown_delay_cap, fault_n, irq;
  logic upper_drive_a, upper_drive_b, upper_drive_c;
  logic lower_drive_a, lower_drive_b, lower_drive_c;
  logic [2:0] uv_trip;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] drv;
  int error_cnt, checks, cyc;
  assign drv = {upper_drive_a, upper_drive_b, upper_drive_c,
                lower_drive_a, lower_drive_b, lower_drive_c};

  // ==========================================================
  // design and far side
  // short latch delay keeps the run brief
  bldc_core #(.LATCH_DELAY(20)) i_bldc_core (
    .clk_sys, .arst_n, .hall_input_a, .hall_input_b, .hall_input_c, .out_enable, .brake,
    .fwd_rev, .phase_sel_60, .over_current, .uv_supply(uv_trip[0]),
    .uv_drive_supply(uv_trip[1]), .uv_reference(uv_trip[2]), .thermal_shutdown,
    .shutdown_delay_cap, .upper_drive_a, .upper_drive_b, .upper_drive_c, .lower_drive_a,
    .lower_drive_b, .lower_drive_c, .fault_n, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bldc_motor_model i_bldc_motor_model (
    .clk_sys, .arst_n, .step, .sel60(phase_sel_60), .bad, .oc_cmd, .brake_sw,
    .hall_input_a, .hall_input_b, .hall_input_c, .over_current, .brake, .shutdown_delay_cap);

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // handshakes are judged at the negedge before the edge that takes them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic pa, pw, pb, ta, tw, tb;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {pa, pw, pb} = 3'h7;
    for (int n = 0; n < 100 && (pa || pw || pb); n++) begin
      @(negedge clk_sys);
      {ta, tw, tb} = {pa && s_axi_awready, pw && s_axi_wready, pb && s_axi_bvalid};
      if (tb) r = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      {pa, pw, pb} = {pa && !ta, pw && !tw, pb && !tb};
    end
    chk("wr done", 32'h0, {pa, pw, pb});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pr, ta, tr;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    {pa, pr} = 2'h3;
    for (int n = 0; n < 100 && (pa || pr); n++) begin
      @(negedge clk_sys);
      {ta, tr} = {pa && s_axi_arready, pr && s_axi_rvalid};
      if (tr) {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      {pa, pr} = {pa && !ta, pr && !tr};
    end
    chk("rd done", 32'h0, {pa, pr});
  endtask

  // outside speed selector, ten percent steps, top codes full on
  function automatic logic [31:0] duty_of(input logic [3:0] c);
    return (c > 4'h9) ? 32'h3e8 : c * 32'h64;
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(bldc_pkg::CTRL_OFS, d, r);
    chk("ctrl", {30'h0, bldc_pkg::CTRL_RST}, d);
    axi_rd(bldc_pkg::IRQ_EN_OFS, d, r);
    chk("irq_en", 32'h0, d);
    axi_rd(bldc_pkg::DUTY_OFS, d, r);
    chk("duty", 32'h0, d);
    chk("drives", 6'h20, drv);
    axi_wr(bldc_pkg::DUTY_OFS, 32'h3e8, 4'h1, r);
    axi_rd(bldc_pkg::DUTY_OFS, d, r);
    chk("duty strobe", 32'he8, d);
    axi_rd(8'h20, d, r);
    chk("rd resp", bldc_pkg::RESP_SLVERR, r);
    chk("rd data", 32'h0, d);
    axi_wr(8'h20, 32'h1, 4'hf, r);
    chk("wr resp", bldc_pkg::RESP_SLVERR, r);
    axi_rd(bldc_pkg::IRQ_CLR_OFS, d, r);
    chk("irq_clr", 32'h0, d);
  endtask

  task automatic t_steps();
    logic [1:0] r;
    logic [2:0] tp [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4};
    logic [2:0] bp [6] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2};
    axi_wr(bldc_pkg::DUTY_OFS, duty_of(4'hf), 4'hf, r);
    hold(1100);
    for (int f = 0; f < 2; f++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge clk_sys);
        fwd_rev <= f[0];
        phase_sel_60 <= s[0];
        for (int k = 0; k < 6; k++) begin
          hold(4);
          chk("step", f[0] ? {tp[k], bp[k]} : {bp[k], tp[k]}, drv);
          @(posedge clk_sys);
          step <= 1'h1;
          @(posedge clk_sys);
          step <= 1'h0;
        end
      end
    end
  endtask

  task automatic t_faults();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(bldc_pkg::IRQ_EN_OFS, 32'h1, 4'hf, r);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      bad <= (i == 0);
      out_enable <= (i != 1);
      oc_cmd <= (i == 2);
      uv_trip <= (i > 2 && i < 6) ? 3'h1 << (i - 3) : 3'h0;
      thermal_shutdown <= (i == 6);
      hold(4);
      chk("fault_n", 1'h0, fault_n);
      chk("drives", (i == 2) ? 6'h20 : 6'h0, drv);
      chk("irq", 1'h1, irq);
      @(posedge clk_sys);
      {bad, oc_cmd, thermal_shutdown, uv_trip, out_enable} <= 7'h1;
      hold(4);
      chk("fault_n", 1'h1, fault_n);
      if (i == 2) chk("held off", 6'h20, drv);
    end
    hold(1000);
    chk("drives", 6'h21, drv);
    axi_wr(bldc_pkg::IRQ_EN_OFS, 32'h0, 4'hf, r);
    hold(1);
    chk("irq masked", 1'h0, irq);
    axi_rd(bldc_pkg::IRQ_STAT_OFS, d, r);
    chk("irq_stat", 32'hb, d);
    axi_wr(bldc_pkg::IRQ_CLR_OFS, 32'hf, 4'hf, r);
    axi_wr(bldc_pkg::IRQ_EN_OFS, 32'hf, 4'hf, r);
    axi_rd(bldc_pkg::IRQ_STAT_OFS, d, r);
    chk("irq_stat", 32'h0, d);
    chk("irq", 1'h0, irq);
  endtask

  task automatic t_latch();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(bldc_pkg::CTRL_OFS, 32'h3, 4'hf, r);
    for (int g = 0; g < 2; g++) begin
      @(posedge clk_sys);
      oc_cmd <= 1'h1;
      repeat (15) @(posedge clk_sys);
      oc_cmd <= 1'h0;
    end
    hold(4);
    chk("gap", 1'h1, fault_n);
    @(posedge clk_sys);
    oc_cmd <= 1'h1;
    repeat (30) @(posedge clk_sys);
    oc_cmd <= 1'h0;
    hold(6);
    chk("latched fault_n", 1'h0, fault_n);
    axi_rd(bldc_pkg::STATE_OFS, d, r);
    chk("latched", 1'h1, d[15]);
    @(posedge clk_sys);
    brake_sw <= 1'h1;
    hold(4);
    @(posedge clk_sys);
    brake_sw <= 1'h0;
    hold(4);
    chk("released fault_n", 1'h1, fault_n);
    axi_rd(bldc_pkg::STATE_OFS, d, r);
    chk("latched", 1'h0, d[15]);
  endtask

  task automatic t_brake();
    @(posedge clk_sys);
    brake_sw <= 1'h1;
    hold(4);
    chk("brake drives", 6'h07, drv);
    chk("brake fault_n", 1'h1, fault_n);
    @(posedge clk_sys);
    out_enable <= 1'h0;
    hold(4);
    chk("brake fault_n", 1'h0, fault_n);
    @(posedge clk_sys);
    uv_trip <= 3'h4;
    hold(4);
    chk("uv drives", 6'h0, drv);
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {arst_n, thermal_shutdown, step, bad, oc_cmd, brake_sw, uv_trip} = 9'h0;
    {out_enable, fwd_rev, phase_sel_60} = 3'h7;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {error_cnt, checks, cyc} = '0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_regs();
    t_steps();
    t_faults();
    t_latch();
    t_brake();
    close_out();
  end
endmodule
